// [test/ttx_mem_model.sv]
// Behavioural core memory facing the table transfer engine.
// Assumes one read in flight at a time; the bench sets the read latency.
`timescale 1ns/10ps
module ttx_mem_model (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic [3:0] i_lat,
    input wire logic [14:0] i_addr,
    input wire logic [23:0] i_wdata,
    input wire logic i_rd,
    input wire logic i_wr,
    output logic [23:0] o_rdata,
    output logic o_rvalid
);
    logic [23:0] mem [0:32767];
    logic [14:0] rd_addr;
    logic [3:0] wait_cnt;
    logic pend;

    // ------------------------------------------------------------
    // Write port, taken in the cycle of the strobe
    // ------------------------------------------------------------
    always @(posedge i_sys_clk)
    begin
        if (i_wr)
            mem[i_addr] <= i_wdata;
    end

    // ------------------------------------------------------------
    // Read answer after i_lat extra cycles, data scrambled otherwise
    // ------------------------------------------------------------
    always @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            pend <= 1'b0;
            wait_cnt <= 4'h0;
            rd_addr <= 15'h0;
            o_rvalid <= 1'b0;
            o_rdata <= 24'h0;
        end
        else
        begin
            o_rvalid <= 1'b0;
            o_rdata <= ~o_rdata;
            if (i_rd)
            begin
                pend <= 1'b1;
                wait_cnt <= i_lat;
                rd_addr <= i_addr;
            end
            else if (pend && wait_cnt != 4'h0)
                wait_cnt <= wait_cnt - 4'h1;
            else if (pend)
            begin
                pend <= 1'b0;
                o_rvalid <= 1'b1;
                o_rdata <= mem[rd_addr];
            end
        end
    end
endmodule // ttx_mem_model

// [test/ttx_table_io_test.sv]
// Self-checking bench for the table transfer engine.
// Assumes the default channel decode of the package and the memory model beside it.
`timescale 1ns/10ps
module ttx_table_io_test;
    logic i_sys_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [47:0] i_chan_irq = 48'h0;
    logic [23:0] i_dev_char = 24'h0;
    logic [1:0] i_reg_addr = 2'h0;
    logic [23:0] i_reg_wdata = 24'h0;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic [3:0] mem_lat = 4'h0;
    logic [3:0] o_dev_code;
    logic o_dev_in_strobe, o_dev_out_strobe, o_echo, o_busy, o_mem_rd, o_mem_wr, mem_rvalid;
    logic [23:0] o_dev_char, o_mem_wdata, mem_rdata, o_reg_rdata, out_char;
    logic [14:0] o_mem_addr;
    int n_fail = 0;
    int cmp_count = 0;
    int cycles = 0;
    int n_echo, n_in, n_out, n_wr, n_busy, i;

    ttx_table_io i_dut (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_chan_irq(i_chan_irq),
        .i_dev_char(i_dev_char), .o_dev_code(o_dev_code), .o_dev_in_strobe(o_dev_in_strobe),
        .o_dev_out_strobe(o_dev_out_strobe), .o_dev_char(o_dev_char), .o_echo(o_echo), .o_busy(o_busy),
        .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
        .i_mem_rdata(mem_rdata), .i_mem_rvalid(mem_rvalid), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata));
    ttx_mem_model i_mem (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_lat(mem_lat), .i_addr(o_mem_addr),
        .i_wdata(o_mem_wdata), .i_rd(o_mem_rd), .i_wr(o_mem_wr), .o_rdata(mem_rdata), .o_rvalid(mem_rvalid));

    always #25 i_sys_clk = ~i_sys_clk;

    // ------------------------------------------------------------
    // Pulse counters and hang limit, sampled where outputs are settled
    // ------------------------------------------------------------
    always @(negedge i_sys_clk)
    begin
        cycles++;
        if (o_echo === 1'b1) n_echo++;
        if (o_dev_in_strobe === 1'b1) n_in++;
        if (o_dev_out_strobe === 1'b1) out_char = o_dev_char;
        if (o_dev_out_strobe === 1'b1) n_out++;
        if (o_mem_wr === 1'b1) n_wr++;
        if (o_busy === 1'b1) n_busy++;
        if (cycles == 20000)
        begin
            n_fail++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic reg_wr(input logic [1:0] a, input logic [23:0] d);
        @(posedge i_sys_clk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_reg_wr <= 1'b0;
    endtask

    task automatic reg_chk(input string what, input logic [1:0] a, input logic [23:0] exp);
        @(posedge i_sys_clk);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_reg_rd <= 1'b0;
        @(negedge i_sys_clk);
        check(what, o_reg_rdata, exp);
    endtask

    function automatic logic [23:0] rotl(input logic [23:0] w, input logic [1:0] p);
        case (p)
            2'h0: return {w[17:0], w[23:18]};
            2'h1: return {w[15:0], w[23:16]};
            2'h2: return {w[11:0], w[23:12]};
            default: return w;
        endcase
    endfunction

    task automatic load(input int ch, input logic [1:0] p, input logic [5:0] words, input logic [13:0] y,
                        input logic [23:0] d0, input logic [23:0] d1);
        i_mem.mem[ttx_pkg::RESP_BASE + 15'(ch)] = {~words, p, p, y - 14'h1};
        i_mem.mem[{1'b0, y}] = d0;
        i_mem.mem[{1'b0, y + 14'h1}] = d1;
    endtask

    // One interrupt on channel ch, predicted from the control word in memory
    task automatic seq(input int ch, input logic [23:0] chr, input logic hold);
        ttx_pkg::ttx_cw_t old, nw;
        logic [14:0] ra;
        logic [23:0] w, msk;
        logic inp, live;
        int k;
        ra = ttx_pkg::RESP_BASE + 15'(ch);
        old = i_mem.mem[ra];
        inp = ttx_pkg::INPUT_MASK[ch];
        live = old.n != ttx_pkg::N_DONE;
        nw = old;
        if (live)
        begin
            nw.c = old.c + 2'h1;
            nw.n = old.n + 6'(old.c == 2'h3);
            nw.y = old.y + 14'(old.c == old.p);
            if (nw.c == 2'h0) nw.c = old.p;
        end
        msk = (old.p == 2'h0) ? 24'h3f : (old.p == 2'h1) ? 24'hff : (old.p == 2'h2) ? 24'hfff : 24'hffffff;
        w = (inp && old.c == old.p) ? 24'h0 : i_mem.mem[{1'b0, nw.y}];
        w = live ? rotl(w, old.p) | (inp ? chr : 24'h0) : i_mem.mem[{1'b0, nw.y}];
        if (hold) reg_wr(ttx_pkg::REG_CTRL, 24'h0);
        @(posedge i_sys_clk);
        i_dev_char <= chr;
        repeat (3) @(posedge i_sys_clk);
        n_echo = 0; n_in = 0; n_out = 0; n_wr = 0; n_busy = 0;
        i_chan_irq[ch] <= 1'b1;
        if (hold)
        begin
            repeat (10) @(negedge i_sys_clk);
            check("held", 24'(o_busy), 24'h0);
            reg_wr(ttx_pkg::REG_CTRL, 24'h1);
        end
        for (k = 0; k < 20 && o_busy !== 1'b1; k++) @(negedge i_sys_clk);
        reg_chk("status", ttx_pkg::REG_STATUS, {16'h0, 1'b1, inp, 6'(ch)});
        check("dev_code", 24'(o_dev_code), 24'(ttx_pkg::DEV_CODES[4*ch +: 4]));
        @(posedge i_sys_clk);
        i_chan_irq[ch] <= 1'b0;
        for (k = 0; k < 1000 && o_busy === 1'b1; k++) @(negedge i_sys_clk);
        @(posedge i_sys_clk);
        i_dev_char <= ~chr;
        check("cw", i_mem.mem[ra], nw);
        check("word", i_mem.mem[{1'b0, nw.y}], w);
        check("echo", 24'(n_echo), 24'(live && nw.n == 6'h3f));
        check("in_strobe", 24'(n_in), 24'(live && inp));
        check("out_strobe", 24'(n_out), 24'(live && !inp));
        check("mem_wr", 24'(n_wr), live ? 24'h2 : 24'h0);
        check("busy_len", 24'(n_busy), ttx_pkg::DEV_CODES[4*ch+3] ? 24'(ttx_pkg::SLOW_SEQ_CYC)
                                                                  : 24'(ttx_pkg::FAST_SEQ_CYC));
        if (live && !inp) check("char", out_char & msk, w & msk);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        @(negedge i_sys_clk);
        check("busy_rst", 24'({o_busy, o_echo, o_mem_rd, o_mem_wr}), 24'h0);
        reg_chk("ctrl_rst", ttx_pkg::REG_CTRL, 24'h1);
        reg_chk("echo_rst", ttx_pkg::REG_ECHO_CNT, 24'h0);
        load(0, 2'h1, 6'd2, 14'h0100, 24'ha5a5a5, 24'h5a5a5a);
        load(1, 2'h0, 6'd1, 14'h0200, 24'h3c5a96, 24'h0);
        load(2, 2'h3, 6'd1, 14'h0300, 24'hffffff, 24'h0);
        load(3, 2'h2, 6'd1, 14'h0400, 24'habc123, 24'h0);
        for (i = 0; i < 6; i++) seq(0, 24'(8'h11 * (i + 1)), 1'b0);
        seq(0, 24'h77, 1'b1);
        mem_lat <= 4'h3;
        for (i = 0; i < 4; i++) seq(1, 24'h0, 1'b0);
        mem_lat <= 4'h7;
        seq(2, 24'h9abcde, 1'b0);
        for (i = 0; i < 2; i++) seq(3, 24'h0, 1'b0);
        reg_chk("echo_cnt", ttx_pkg::REG_ECHO_CNT, 24'h4);
        reg_wr(ttx_pkg::REG_ECHO_CNT, 24'h0);
        reg_chk("echo_clr", ttx_pkg::REG_ECHO_CNT, 24'h0);
        reg_wr(2'h3, 24'hffffff);
        reg_chk("unmapped", 2'h3, 24'h0);
        report_and_stop();
    end
endmodule // ttx_table_io_test

// [verilog/ttx_chan_map.sv]
// Wired channel decode: channel index to response address, device code and direction.
// Assumes the channel index is below the channel count.
`timescale 1ns/10ps
module ttx_chan_map #(
    parameter logic [14:0] BASE = ttx_pkg::RESP_BASE,
    parameter logic [47:0] IN_MASK = ttx_pkg::INPUT_MASK,
    parameter logic [191:0] CODES = ttx_pkg::DEV_CODES
) (
    input wire logic [5:0] i_chan,
    output ttx_pkg::ttx_chan_t o_info
);

    // ---------------------------------------------------------------
    // Fixed decode
    // ---------------------------------------------------------------
    always_comb
    begin
        o_info.resp_addr = BASE + {9'h000, i_chan};
        o_info.dev_code = CODES[{i_chan, 2'h0} +: 4];
        o_info.is_input = IN_MASK[i_chan];
    end

endmodule // ttx_chan_map

// [verilog/ttx_pkg.sv]
// Package for the interrupt-driven table transfer engine.
// Assumes a 20 MHz system clock and a 24-bit core memory behind a simple request port.
package ttx_pkg;

    // ---------------------------------------------------------------
    // Sizes and channel decode
    // ---------------------------------------------------------------
    localparam int NUM_CHAN = 48;
    localparam int WORD_W = 24;
    localparam int MADDR_W = 15;
    localparam logic [14:0] RESP_BASE = 15'h0040;
    localparam logic [47:0] INPUT_MASK = 48'h5555_5555_5555;
    localparam logic [191:0] DEV_CODES = {12{16'hfa31}};

    // ---------------------------------------------------------------
    // Control word fields
    // ---------------------------------------------------------------
    localparam logic [5:0] N_DONE = 6'h3f;
    localparam logic [1:0] C_WRAP = 2'h3;
    localparam logic [1:0] PACK_FOUR = 2'h0;
    localparam logic [1:0] PACK_THREE = 2'h1;
    localparam logic [1:0] PACK_TWO = 2'h2;
    localparam logic [4:0] WIDTH_FOUR = 5'h06;
    localparam logic [4:0] WIDTH_THREE = 5'h08;
    localparam logic [4:0] WIDTH_TWO = 5'h0c;
    localparam logic [4:0] WIDTH_ONE = 5'h18;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int FAST_SEQ_NS = 12700;
    localparam int SLOW_SEQ_NS = 30700;
    localparam logic [9:0] FAST_SEQ_CYC = 10'(FAST_SEQ_NS / CLK_PERIOD_NS);
    localparam logic [9:0] SLOW_SEQ_CYC = 10'(SLOW_SEQ_NS / CLK_PERIOD_NS);

    // ---------------------------------------------------------------
    // Register port
    // ---------------------------------------------------------------
    localparam logic [1:0] REG_CTRL = 2'h0;
    localparam logic [1:0] REG_STATUS = 2'h1;
    localparam logic [1:0] REG_ECHO_CNT = 2'h2;
    localparam logic CTRL_ENABLE_RST = 1'b1;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [5:0] n;
        logic [1:0] c;
        logic [1:0] p;
        logic [13:0] y;
    } ttx_cw_t;

    typedef struct packed {
        logic [14:0] resp_addr;
        logic [3:0] dev_code;
        logic is_input;
    } ttx_chan_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_FETCH = 3'h1,
        S_CW_STORE = 3'h3,
        S_DATA_READ = 3'h2,
        S_DATA_STORE = 3'h6,
        S_PAD = 3'h4
    } ttx_state_t;

endpackage

// [verilog/ttx_table_io.sv]
// Interrupt-driven table transfer engine: moves characters between peripherals and memory.
// Assumes memory answers a read with i_mem_rvalid and accepts a write in one cycle.
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/10ps

// Notes on behaviour
// - A peripheral interrupt alone starts one transfer sequence, no instruction involved.
// - Only the buffer carries data; no processor register is touched.
// - Each channel decodes to a fixed device code and direction.
// - The control word at the response address is fetched first.
// - Upper six bits hold the remaining word count in ones complement, 63 max.
// - Packing 00/01/10/11 gives four, three, two, one characters per word.
// - Table address advances when character count equals packing.
// - Character count advances by one unless the control word is exhausted.
// - Character count wrap carries into word count.
// - Word count reaching all ones raises the completion echo.
// - Character count at zero after update reloads from packing.
// - Updated control word returns to the response address.
// - Input reads the table word, or clears the buffer on a word's first character.
// - Input rotates the buffer left by one character width.
// - Input ORs the received character into the low bits.
// - The merged buffer is written back at the table address.
// - Output channels drive characters out through the same sequence.
// - A sequence lasts 12.7 us on fast channels, 30.7 us on slow ones.
// - Up to 48 channels, each with its own interrupt and decode.
// - Output rotates the word left, sends the low character, stores it back.
// - An exhausted control word ends the sequence with no data moved.
module ttx_table_io (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic [47:0] i_chan_irq,
    input wire logic [23:0] i_dev_char,
    output logic [3:0] o_dev_code,
    output logic o_dev_in_strobe,
    output logic o_dev_out_strobe,
    output logic [23:0] o_dev_char,
    output logic o_echo,
    output logic o_busy,
    output logic [14:0] o_mem_addr,
    output logic [23:0] o_mem_wdata,
    output logic o_mem_rd,
    output logic o_mem_wr,
    input wire logic [23:0] i_mem_rdata,
    input wire logic i_mem_rvalid,
    input wire logic [1:0] i_reg_addr,
    input wire logic [23:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [23:0] o_reg_rdata
);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        ttx_pkg::ttx_state_t state;
        logic [47:0] irq_s1;
        logic [47:0] irq_s2;
        logic [47:0] irq_prev;
        logic [47:0] pending;
        logic [23:0] char_s1;
        logic [23:0] char_s2;
        logic [5:0] chan;
        ttx_pkg::ttx_cw_t cw;
        ttx_pkg::ttx_cw_t cwn;
        logic [23:0] buffer;
        logic [9:0] cycles;
        logic enable;
        logic [7:0] echo_count;
        logic [14:0] mem_addr;
        logic [23:0] mem_wdata;
        logic mem_rd;
        logic mem_wr;
        logic [3:0] dev_code;
        logic dev_in_strobe;
        logic dev_out_strobe;
        logic [23:0] dev_char;
        logic echo;
        logic busy;
        logic [23:0] reg_rdata;
    } ttx_core_t;

    ttx_core_t r;
    ttx_core_t next_r;
    ttx_pkg::ttx_chan_t info;
    ttx_pkg::ttx_cw_t fetched;
    ttx_pkg::ttx_cw_t updated;
    logic [2:0] c_sum;
    logic [4:0] width;
    logic [23:0] mask;
    logic [23:0] rotated;
    logic [23:0] rot_src;
    logic [47:0] rose;
    logic [5:0] pick;
    logic found;
    logic [9:0] seq_len;

    // ---------------------------------------------------------------
    // Channel decode
    // ---------------------------------------------------------------
    ttx_chan_map u_map (
        .i_chan(r.chan),
        .o_info(info)
    );

    // ---------------------------------------------------------------
    // Datapath helpers
    // ---------------------------------------------------------------
    always_comb
    begin
        fetched = ttx_pkg::ttx_cw_t'(i_mem_rdata);
        c_sum = {1'b0, fetched.c} + 3'h1;
        updated.c = (c_sum[1:0] == 2'h0) ? fetched.p : c_sum[1:0];
        updated.p = fetched.p;
        updated.n = fetched.n + {5'h00, c_sum[2]};
        updated.y = fetched.y + {13'h0000, fetched.c == fetched.p};
        case (r.cw.p)
            ttx_pkg::PACK_FOUR: width = ttx_pkg::WIDTH_FOUR;
            ttx_pkg::PACK_THREE: width = ttx_pkg::WIDTH_THREE;
            ttx_pkg::PACK_TWO: width = ttx_pkg::WIDTH_TWO;
            default: width = ttx_pkg::WIDTH_ONE;
        endcase
        mask = 24'((25'h0000001 << width) - 25'h0000001);
        rot_src = i_mem_rdata;
        rotated = 24'((rot_src << width) | (rot_src >> (5'h18 - width)));
        seq_len = info.dev_code[3] ? ttx_pkg::SLOW_SEQ_CYC : ttx_pkg::FAST_SEQ_CYC;
        rose = r.irq_s2 & ~r.irq_prev;
        found = 1'b0;
        pick = 6'h00;
        for (int i = 0; i < ttx_pkg::NUM_CHAN; i++)
        begin
            if (!found && r.pending[i])
            begin
                found = 1'b1;
                pick = 6'(i);
            end
        end
    end

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb
    begin
        next_r = r;
        next_r.irq_s1 = i_chan_irq;
        next_r.irq_s2 = r.irq_s1;
        next_r.irq_prev = r.irq_s2;
        next_r.char_s1 = i_dev_char;
        next_r.char_s2 = r.char_s1;
        next_r.mem_rd = 1'b0;
        next_r.mem_wr = 1'b0;
        next_r.dev_in_strobe = 1'b0;
        next_r.dev_out_strobe = 1'b0;
        next_r.echo = 1'b0;
        next_r.reg_rdata = 24'h000000;
        next_r.cycles = r.cycles + 10'h001;
        next_r.pending = r.pending | rose;
        case (r.state)
            ttx_pkg::S_IDLE:
            begin
                next_r.cycles = 10'h000;
                if (r.enable && found)
                begin
                    next_r.pending[pick] = rose[pick];
                    next_r.chan = pick;
                    next_r.busy = 1'b1;
                    next_r.mem_rd = 1'b1;
                    next_r.mem_addr = ttx_pkg::RESP_BASE + {9'h000, pick};
                    next_r.state = ttx_pkg::S_FETCH;
                end
            end
            ttx_pkg::S_FETCH:
            begin
                if (i_mem_rvalid)
                begin
                    next_r.cw = fetched;
                    next_r.cwn = updated;
                    if (fetched.n == ttx_pkg::N_DONE)
                    begin
                        next_r.state = ttx_pkg::S_PAD;
                    end
                    else
                    begin
                        next_r.mem_wr = 1'b1;
                        next_r.mem_addr = info.resp_addr;
                        next_r.mem_wdata = updated;
                        next_r.echo = c_sum[2] && (updated.n == ttx_pkg::N_DONE);
                        next_r.state = ttx_pkg::S_CW_STORE;
                    end
                end
            end
            ttx_pkg::S_CW_STORE:
            begin
                if (info.is_input && (r.cw.c == r.cw.p))
                begin
                    next_r.buffer = r.char_s2 & mask;
                    next_r.dev_in_strobe = 1'b1;
                    next_r.mem_wr = 1'b1;
                    next_r.mem_addr = {1'b0, r.cwn.y};
                    next_r.mem_wdata = r.char_s2 & mask;
                    next_r.state = ttx_pkg::S_DATA_STORE;
                end
                else
                begin
                    next_r.mem_rd = 1'b1;
                    next_r.mem_addr = {1'b0, r.cwn.y};
                    next_r.state = ttx_pkg::S_DATA_READ;
                end
            end
            ttx_pkg::S_DATA_READ:
            begin
                if (i_mem_rvalid)
                begin
                    next_r.mem_wr = 1'b1;
                    if (info.is_input)
                    begin
                        next_r.buffer = rotated | (r.char_s2 & mask);
                        next_r.mem_wdata = rotated | (r.char_s2 & mask);
                        next_r.dev_in_strobe = 1'b1;
                    end
                    else
                    begin
                        next_r.buffer = rotated;
                        next_r.mem_wdata = rotated;
                        next_r.dev_char = rotated & mask;
                        next_r.dev_out_strobe = 1'b1;
                    end
                    next_r.state = ttx_pkg::S_DATA_STORE;
                end
            end
            ttx_pkg::S_DATA_STORE:
            begin
                next_r.state = ttx_pkg::S_PAD;
            end
            default:
            begin
                if (r.cycles >= seq_len - 10'h001)
                begin
                    next_r.busy = 1'b0;
                    next_r.state = ttx_pkg::S_IDLE;
                end
            end
        endcase
        next_r.dev_code = info.dev_code;
        next_r.echo_count = r.echo_count + {7'h00, r.echo};
        if (i_reg_wr && i_reg_addr == ttx_pkg::REG_CTRL)
        begin
            next_r.enable = i_reg_wdata[0];
        end
        else if (i_reg_wr && i_reg_addr == ttx_pkg::REG_ECHO_CNT)
        begin
            next_r.echo_count = {7'h00, r.echo};
        end
        if (i_reg_rd && i_reg_addr == ttx_pkg::REG_CTRL)
        begin
            next_r.reg_rdata = {23'h000000, r.enable};
        end
        else if (i_reg_rd && i_reg_addr == ttx_pkg::REG_STATUS)
        begin
            next_r.reg_rdata = {16'h0000, r.busy, info.is_input, r.chan};
        end
        else if (i_reg_rd && i_reg_addr == ttx_pkg::REG_ECHO_CNT)
        begin
            next_r.reg_rdata = {16'h0000, r.echo_count};
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            r <= '0;
            r.state <= ttx_pkg::S_IDLE;
            r.enable <= ttx_pkg::CTRL_ENABLE_RST;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign o_dev_code = r.dev_code;
    assign o_dev_in_strobe = r.dev_in_strobe;
    assign o_dev_out_strobe = r.dev_out_strobe;
    assign o_dev_char = r.dev_char;
    assign o_echo = r.echo;
    assign o_busy = r.busy;
    assign o_mem_addr = r.mem_addr;
    assign o_mem_wdata = r.mem_wdata;
    assign o_mem_rd = r.mem_rd;
    assign o_mem_wr = r.mem_wr;
    assign o_reg_rdata = r.reg_rdata;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    property p_fetch_first;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        $rose(r.busy) |-> o_mem_rd && o_mem_addr == info.resp_addr;
    endproperty
    a_fetch_first: assert property (p_fetch_first) else $error("Fetch not at response address");
    property p_cw_back;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        r.state == ttx_pkg::S_CW_STORE |-> o_mem_wr && o_mem_addr == info.resp_addr;
    endproperty
    a_cw_back: assert property (p_cw_back) else $error("Control word not written back");
    property p_addr_step;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        r.state == ttx_pkg::S_CW_STORE |->
            o_mem_wdata[13:0] == r.cw.y + ((r.cw.c == r.cw.p) ? 14'h0001 : 14'h0000);
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("Table address step wrong");
    property p_count_step;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        r.state == ttx_pkg::S_CW_STORE |->
            o_mem_wdata[17:16] == ((r.cw.c == ttx_pkg::C_WRAP) ? r.cw.p : r.cw.c + 2'h1)
            && o_mem_wdata[23:18] == r.cw.n + ((r.cw.c == ttx_pkg::C_WRAP) ? 6'h01 : 6'h00);
    endproperty
    a_count_step: assert property (p_count_step) else $error("Count fields updated wrongly");
    property p_echo;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        o_echo |-> o_mem_wr && o_mem_wdata[23:18] == ttx_pkg::N_DONE && r.cw.c == ttx_pkg::C_WRAP
            ##1 !o_echo;
    endproperty
    a_echo: assert property (p_echo) else $error("Echo without final character");
    property p_exhausted;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        $past(r.state) == ttx_pkg::S_FETCH && r.state == ttx_pkg::S_PAD |->
            (!o_mem_wr && !o_dev_out_strobe && !o_dev_in_strobe) throughout (r.busy [*1]);
    endproperty
    a_exhausted: assert property (p_exhausted) else $error("Data moved on exhausted word");
    property p_data_store;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        r.state == ttx_pkg::S_DATA_STORE |-> o_mem_wr && o_mem_addr == {1'b0, r.cwn.y};
    endproperty
    a_data_store: assert property (p_data_store) else $error("Data stored at wrong address");
    property p_first_clear;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        r.state == ttx_pkg::S_DATA_STORE && info.is_input && r.cw.c == r.cw.p |->
            (o_mem_wdata & ~mask) == 24'h000000;
    endproperty
    a_first_clear: assert property (p_first_clear) else $error("First character not on clear word");
    property p_out_char;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        o_dev_out_strobe |-> o_dev_char == (o_mem_wdata & mask) && o_mem_wr;
    endproperty
    a_out_char: assert property (p_out_char) else $error("Output character mismatch");
    property p_duration;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        $fell(r.busy) |-> $past(r.cycles) >= $past(seq_len) - 10'h001;
    endproperty
    a_duration: assert property (p_duration) else $error("Sequence ended early");

    c_echo: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n) o_echo);
    c_input: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n) o_dev_in_strobe);
    c_output: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n) o_dev_out_strobe);
    c_exhausted: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        $past(r.state) == ttx_pkg::S_FETCH && r.state == ttx_pkg::S_PAD);

endmodule // ttx_table_io
